//--- pic_pkg.sv
// constants, types and helper functions for the priority interrupt controller
// assumes a single 100 MHz clock domain; all pin inputs are synchronised

package pic_pkg;

	localparam int PIC_NUM_IRQ = 8;
	localparam logic [7:0] PIC_CALL_OPCODE = 8'hcd;

	// init_word_first field positions
	localparam int PIC_IW1_SEL = 4;
	localparam int PIC_IW1_LEVEL_TRIGGER_SEL = 3;
	localparam int PIC_IW1_VECTOR_SPACING_SEL = 2;
	localparam int PIC_IW1_SINGLE_DEVICE_FLAG = 1;
	localparam int PIC_IW1_FOURTH_WORD_NEEDED = 0;

	// init_word_mode_options field positions
	localparam int PIC_IW4_SPECIAL_NESTED = 4;
	localparam int PIC_IW4_BUFFERED = 3;
	localparam int PIC_IW4_MASTER = 2;
	localparam int PIC_IW4_AUTO_END = 1;
	localparam int PIC_IW4_PROCESSOR_TYPE = 0;

	// op_word_mask_mode field positions
	localparam int PIC_OW3_SEL = 3;
	localparam int PIC_OW3_MASK_MODE_WRITE_ENABLE = 6;
	localparam int PIC_OW3_SPECIAL_MASKING_ON = 5;
	localparam int PIC_OW3_READ_REG = 1;
	localparam int PIC_OW3_READ_IN_SERVICE = 0;

	// op_word_eoi_rotate command codes, bits 7-5
	localparam logic [2:0] PIC_CMD_ROT_AUTO_CLR = 3'h0;
	localparam logic [2:0] PIC_CMD_EOI_ANY = 3'h1;
	localparam logic [2:0] PIC_CMD_NOP = 3'h2;
	localparam logic [2:0] PIC_CMD_EOI_LEVEL = 3'h3;
	localparam logic [2:0] PIC_CMD_ROT_AUTO_SET = 3'h4;
	localparam logic [2:0] PIC_CMD_ROT_EOI_ANY = 3'h5;
	localparam logic [2:0] PIC_CMD_SET_PRIO = 3'h6;
	localparam logic [2:0] PIC_CMD_ROT_EOI_LEVEL = 3'h7;

	// acknowledge pulse counts and reset values
	localparam logic [1:0] PIC_ACK_LAST_8BIT = 2'h3;
	localparam logic [1:0] PIC_ACK_LAST_16BIT = 2'h2;
	localparam logic [2:0] PIC_BASE_RST = 3'h7;
	localparam logic [2:0] PIC_DEFAULT_LEVEL = 3'h7;
	localparam logic [7:0] PIC_MASK_RST = 8'h00;

	typedef enum logic [1:0] {
		PIC_ST_READY = 2'b00,
		PIC_ST_WORD2 = 2'b01,
		PIC_ST_WORD3 = 2'b10,
		PIC_ST_WORD4 = 2'b11
	} pic_init_st_t;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic a0;
		logic ack_n;
		logic role;
		logic [2:0] cas;
		logic [7:0] data;
	} pic_pins_t;

	localparam pic_pins_t PIC_PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1,
		wr_n: 1'b1, a0: 1'b0, ack_n: 1'b1, role: 1'b1, cas: 3'h0,
		data: 8'h00};

	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] prev;
		logic [7:0] pend;
	} pic_cap_t;

	// highest-priority set bit; base is the lowest-priority level
	function automatic logic [3:0] pic_pick(input logic [7:0] vec,
		input logic [2:0] base);
		logic [3:0] res;
		logic [2:0] lvl;
		res = 4'h0;
		for (int k = 7; k >= 0; k--) begin
			lvl = base + 3'(k) + 3'h1;
			if (vec[lvl]) begin
				res = {1'b1, lvl};
			end
		end
		return res;
	endfunction : pic_pick

	// 0 is the highest rank
	function automatic logic [2:0] pic_rank(input logic [2:0] lvl,
		input logic [2:0] base);
		return lvl - base - 3'h1;
	endfunction : pic_rank

endpackage : pic_pkg

//--- pic_req_capture.sv
// request input synchroniser and pending_request_reg with edge/level sense
// assumes request pins are asynchronous to i_ref_clk

`timescale 1ns/1ns

module pic_req_capture (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// request pins
	input wire logic [pic_pkg::PIC_NUM_IRQ-1:0] i_request_input,
	// control from the controller
	input wire logic i_level_trigger_sel,
	input wire logic i_init_clr,
	input wire logic [pic_pkg::PIC_NUM_IRQ-1:0] i_ack_clr,
	// pending requests
	output logic [pic_pkg::PIC_NUM_IRQ-1:0] o_pending
);
	import pic_pkg::*;

	pic_cap_t st_ff;
	pic_cap_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = i_request_input;
		nxt_st.s2 = st_ff.s1;
		nxt_st.prev = st_ff.s2;
		if (i_init_clr) begin
			// a line already high must drop and rise again
			nxt_st.prev = 8'hff;
			nxt_st.pend = 8'h00;
		end else if (i_level_trigger_sel) begin
			nxt_st.pend = st_ff.s2;
		end else begin
			// new edge wins over a same-cycle acknowledge clear
			nxt_st.pend = ((st_ff.pend & ~i_ack_clr) & st_ff.s2)
				| (st_ff.s2 & ~st_ff.prev);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_pending = st_ff.pend;

endmodule : pic_req_capture

//--- pic_ctrl.sv
// programmable eight-input priority interrupt controller, command decode,
// nesting, end-of-service, rotation, acknowledge vectoring and cascading
// assumes all bus, acknowledge and cascade pins are asynchronous
// Functional notes
// - low address, data bit 4 high starts init
// - init clears edge state, fresh rising needed
// - init clears every channel mask bit
// - init ends special masking, selects pending reads
// - no fourth word forces its options zero
// - 8-bit: spacing four or eight locations
// - 16-bit: five base bits, three level bits
// - level trigger bypasses edge detection
// - third and fourth words only when flagged
// - master: slave lines get cascade code only
// - slave: identity match drives later bytes
// - buffered: pin enables buffer, flag picks role
// - type flag: three-pulse call or two-pulse vector
// - mask word: one inhibits, zero enables
// - enable plus mode bit sets special masking
// - fixed nesting after init, zero highest
// - acknowledge serves highest, blocks equal or lower
// - non-specific end clears highest in-service bit
// - specific end clears the named level
// - automatic end at trailing edge of last pulse
// - auto rotation: serviced level becomes lowest
// - 8-bit first pulse: master or single device sends call opcode, slave stays off the bus
// - high address read returns the mask

`timescale 1ns/1ns

module pic_ctrl (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// processor bus
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_a0,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe_n,
	// interrupt handshake
	input wire logic i_interrupt_ack_n,
	output logic o_int,
	// request inputs
	input wire logic [pic_pkg::PIC_NUM_IRQ-1:0] i_request_input,
	// cascade lines
	input wire logic [2:0] i_cas,
	output logic [2:0] o_cas,
	output logic o_cas_oe_n,
	// dual-purpose role pin or buffer enable
	input wire logic i_role_pin_or_buffer_enable,
	output logic o_role_pin_or_buffer_enable,
	output logic o_role_pin_or_buffer_enable_oe_n
);
	import pic_pkg::*;

	typedef struct packed {
		pic_pins_t s1;
		pic_pins_t s2;
		logic wr_prev;
		logic ack_prev;
		logic w_pend;
		logic w_a0;
		logic [7:0] w_data;
		pic_init_st_t init_st;
		logic [7:0] channel_mask_reg;
		logic [7:0] in_service_reg;
		logic [7:0] vec_hi;
		logic [2:0] vec_lo;
		logic level_trigger_sel;
		logic vector_spacing_sel;
		logic single_device_flag;
		logic fourth_word_needed;
		logic special_nested_enable;
		logic buffered;
		logic master_sel;
		logic auto_end_of_service;
		logic processor_type_sel;
		logic [7:0] cascade_map;
		logic special_masking_on;
		logic read_in_service;
		logic rot_auto;
		logic [2:0] prio_base;
		logic [1:0] ack_cnt;
		logic [2:0] ack_lvl;
		logic ack_route;
		logic init_clr;
		logic [7:0] ack_clr;
		logic int_out;
		logic [7:0] dout;
		logic dout_en;
		logic cas_en;
	} pic_ctrl_st_t;

	localparam pic_ctrl_st_t PIC_CTRL_RST = '{s1: PIC_PINS_IDLE,
		s2: PIC_PINS_IDLE, wr_prev: 1'b1, ack_prev: 1'b1,
		init_st: PIC_ST_READY, channel_mask_reg: PIC_MASK_RST,
		prio_base: PIC_BASE_RST, default: '0};

	pic_ctrl_st_t st_ff;
	pic_ctrl_st_t nxt_st;
	pic_pins_t pins_in;
	logic [7:0] pending_request_reg;

	assign pins_in = '{cs_n: i_cs_n, rd_n: i_rd_n, wr_n: i_wr_n,
		a0: i_a0, ack_n: i_interrupt_ack_n,
		role: i_role_pin_or_buffer_enable, cas: i_cas, data: i_data};

	pic_req_capture u_capture (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_request_input(i_request_input),
		.i_level_trigger_sel(st_ff.level_trigger_sel),
		.i_init_clr(st_ff.init_clr),
		.i_ack_clr(st_ff.ack_clr),
		.o_pending(pending_request_reg)
	);

	// combinational views of the registered state
	logic is_master;
	logic [7:0] eligible;
	logic [3:0] req_top;
	logic [3:0] srv_top;
	logic [3:0] eoi_top;
	logic want_int;
	logic wr_done;
	logic ack_fall;
	logic ack_rise;
	logic [1:0] ack_last;
	logic supply;
	logic [7:0] d;

	always_comb begin
		d = st_ff.w_data;
		// without buffering the master flag is a don't-care
		is_master = st_ff.buffered ? st_ff.master_sel
			: st_ff.s2.role;
		eligible = pending_request_reg & ~st_ff.channel_mask_reg;
		if (st_ff.special_masking_on) begin
			// special masking: only a level's own service blocks it
			eligible = eligible & ~st_ff.in_service_reg;
		end
		req_top = pic_pick(eligible, st_ff.prio_base);
		srv_top = pic_pick(st_ff.in_service_reg, st_ff.prio_base);
		eoi_top = pic_pick(st_ff.special_masking_on
			? (st_ff.in_service_reg & ~st_ff.channel_mask_reg)
			: st_ff.in_service_reg, st_ff.prio_base);
		want_int = req_top[3] && (st_ff.special_masking_on || !srv_top[3]
			|| pic_rank(req_top[2:0], st_ff.prio_base)
			< pic_rank(srv_top[2:0], st_ff.prio_base));
		wr_done = st_ff.w_pend && st_ff.s2.wr_n && !st_ff.wr_prev;
		ack_fall = !st_ff.s2.ack_n && st_ff.ack_prev;
		ack_rise = st_ff.s2.ack_n && !st_ff.ack_prev
			&& (st_ff.ack_cnt != 2'h0);
		ack_last = st_ff.processor_type_sel ? PIC_ACK_LAST_16BIT
			: PIC_ACK_LAST_8BIT;
		// who answers the vector bytes of this acknowledge
		if (st_ff.single_device_flag) begin
			supply = 1'b1;
		end else if (is_master) begin
			supply = !st_ff.ack_route;
		end else begin
			supply = (st_ff.s2.cas == st_ff.cascade_map[2:0]);
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = pins_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.wr_prev = st_ff.s2.wr_n;
		nxt_st.ack_prev = st_ff.s2.ack_n;
		nxt_st.init_clr = 1'b0;
		nxt_st.ack_clr = 8'h00;
		nxt_st.int_out = want_int;
		// hold the write data seen while the strobe is low
		if (!st_ff.s2.cs_n && !st_ff.s2.wr_n) begin
			nxt_st.w_pend = 1'b1;
			nxt_st.w_a0 = st_ff.s2.a0;
			nxt_st.w_data = st_ff.s2.data;
		end
		// commit on the trailing edge of the write strobe
		if (wr_done) begin
			nxt_st.w_pend = 1'b0;
			if (!st_ff.w_a0 && d[PIC_IW1_SEL]) begin
				nxt_st.init_st = PIC_ST_WORD2;
				nxt_st.vec_lo = d[7:5];
				nxt_st.level_trigger_sel = d[PIC_IW1_LEVEL_TRIGGER_SEL];
				nxt_st.vector_spacing_sel = d[PIC_IW1_VECTOR_SPACING_SEL];
				nxt_st.single_device_flag = d[PIC_IW1_SINGLE_DEVICE_FLAG];
				nxt_st.fourth_word_needed = d[PIC_IW1_FOURTH_WORD_NEEDED];
				nxt_st.init_clr = 1'b1;
				nxt_st.channel_mask_reg = PIC_MASK_RST;
				nxt_st.special_masking_on = 1'b0;
				nxt_st.read_in_service = 1'b0;
				nxt_st.in_service_reg = 8'h00;
				nxt_st.prio_base = PIC_BASE_RST;
				nxt_st.rot_auto = 1'b0;
				nxt_st.ack_cnt = 2'h0;
				nxt_st.dout_en = 1'b0;
				nxt_st.cas_en = 1'b0;
				if (!d[PIC_IW1_FOURTH_WORD_NEEDED]) begin
					nxt_st.special_nested_enable = 1'b0;
					nxt_st.buffered = 1'b0;
					nxt_st.master_sel = 1'b0;
					nxt_st.auto_end_of_service = 1'b0;
					nxt_st.processor_type_sel = 1'b0;
				end
			end else if (st_ff.w_a0) begin
				unique case (st_ff.init_st)
					PIC_ST_WORD2: begin
						nxt_st.vec_hi = d;
						if (!st_ff.single_device_flag) begin
							nxt_st.init_st = PIC_ST_WORD3;
						end else if (st_ff.fourth_word_needed) begin
							nxt_st.init_st = PIC_ST_WORD4;
						end else begin
							nxt_st.init_st = PIC_ST_READY;
						end
					end
					PIC_ST_WORD3: begin
						nxt_st.cascade_map = d;
						nxt_st.init_st = st_ff.fourth_word_needed
							? PIC_ST_WORD4 : PIC_ST_READY;
					end
					PIC_ST_WORD4: begin
						nxt_st.special_nested_enable = d[PIC_IW4_SPECIAL_NESTED];
						nxt_st.buffered = d[PIC_IW4_BUFFERED];
						nxt_st.master_sel = d[PIC_IW4_MASTER];
						nxt_st.auto_end_of_service = d[PIC_IW4_AUTO_END];
						nxt_st.processor_type_sel = d[PIC_IW4_PROCESSOR_TYPE];
						nxt_st.init_st = PIC_ST_READY;
					end
					PIC_ST_READY: begin
						nxt_st.channel_mask_reg = d;
					end
				endcase
			end else if (st_ff.init_st == PIC_ST_READY) begin
				if (d[PIC_OW3_SEL]) begin
					// mode bit is a don't-care unless enabled
					if (d[PIC_OW3_MASK_MODE_WRITE_ENABLE]) begin
						nxt_st.special_masking_on =
							d[PIC_OW3_SPECIAL_MASKING_ON];
					end
					if (d[PIC_OW3_READ_REG]) begin
						nxt_st.read_in_service = d[PIC_OW3_READ_IN_SERVICE];
					end
				end else begin
					unique case (d[7:5])
						PIC_CMD_EOI_ANY: begin
							if (eoi_top[3]) begin
								nxt_st.in_service_reg[eoi_top[2:0]] =
									1'b0;
							end
						end
						PIC_CMD_EOI_LEVEL: begin
							nxt_st.in_service_reg[d[2:0]] = 1'b0;
						end
						PIC_CMD_ROT_EOI_ANY: begin
							if (eoi_top[3]) begin
								nxt_st.in_service_reg[eoi_top[2:0]] = 1'b0;
								nxt_st.prio_base = eoi_top[2:0];
							end
						end
						PIC_CMD_ROT_EOI_LEVEL: begin
							nxt_st.in_service_reg[d[2:0]] = 1'b0;
							nxt_st.prio_base = d[2:0];
						end
						PIC_CMD_SET_PRIO: begin
							nxt_st.prio_base = d[2:0];
						end
						PIC_CMD_ROT_AUTO_SET: begin
							nxt_st.rot_auto = 1'b1;
						end
						PIC_CMD_ROT_AUTO_CLR: begin
							nxt_st.rot_auto = 1'b0;
						end
						PIC_CMD_NOP: begin
							nxt_st.rot_auto = st_ff.rot_auto;
						end
					endcase
				end
			end
		end
		// acknowledge sequence
		if (ack_fall) begin
			nxt_st.ack_cnt = st_ff.ack_cnt + 2'h1;
			if (st_ff.ack_cnt == 2'h0) begin
				// freeze the winner; a vanished request answers level 7
				nxt_st.ack_lvl = req_top[3] ? req_top[2:0]
					: PIC_DEFAULT_LEVEL;
				nxt_st.ack_route = 1'b0;
				if (req_top[3]) begin
					nxt_st.in_service_reg[req_top[2:0]] = 1'b1;
					nxt_st.ack_clr[req_top[2:0]] = 1'b1;
					if (is_master && !st_ff.single_device_flag
						&& st_ff.cascade_map[req_top[2:0]]) begin
						nxt_st.ack_route = 1'b1;
						nxt_st.cas_en = 1'b1;
					end
				end
				// 16-bit mode leaves the bus idle on the first pulse
				if (!st_ff.processor_type_sel && (is_master
					|| st_ff.single_device_flag)) begin
					nxt_st.dout = PIC_CALL_OPCODE;
					nxt_st.dout_en = 1'b1;
				end
			end else begin
				nxt_st.dout_en = supply;
				if (st_ff.processor_type_sel) begin
					nxt_st.dout = {st_ff.vec_hi[7:3],
						st_ff.ack_lvl};
				end else if (st_ff.ack_cnt == 2'h2) begin
					nxt_st.dout = st_ff.vec_hi;
				end else if (st_ff.vector_spacing_sel) begin
					nxt_st.dout = {st_ff.vec_lo, st_ff.ack_lvl,
						2'h0};
				end else begin
					nxt_st.dout = {st_ff.vec_lo[2:1], st_ff.ack_lvl,
						3'h0};
				end
			end
		end else if (ack_rise) begin
			nxt_st.dout_en = 1'b0;
			if (st_ff.ack_cnt == ack_last) begin
				nxt_st.ack_cnt = 2'h0;
				nxt_st.cas_en = 1'b0;
				if (st_ff.auto_end_of_service && eoi_top[3]) begin
					nxt_st.in_service_reg[eoi_top[2:0]] = 1'b0;
					if (st_ff.rot_auto) begin
						nxt_st.prio_base = eoi_top[2:0];
					end
				end
			end
		end else if (st_ff.ack_cnt == 2'h0) begin
			// status reads only outside an acknowledge sequence
			nxt_st.dout_en = !st_ff.s2.cs_n && !st_ff.s2.rd_n;
			if (st_ff.s2.a0) begin
				nxt_st.dout = st_ff.channel_mask_reg;
			end else if (st_ff.read_in_service) begin
				nxt_st.dout = st_ff.in_service_reg;
			end else begin
				nxt_st.dout = pending_request_reg;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= PIC_CTRL_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs
	assign o_int = st_ff.int_out;
	assign o_data = st_ff.dout;
	assign o_data_oe_n = !st_ff.dout_en;
	assign o_cas = st_ff.ack_lvl;
	assign o_cas_oe_n = !st_ff.cas_en;
	// pin drives low to open the external transceiver
	assign o_role_pin_or_buffer_enable = !st_ff.dout_en;
	assign o_role_pin_or_buffer_enable_oe_n = !st_ff.buffered;

endmodule : pic_ctrl

//--- pic_ctrl_assertions.sv
// port-level checker for the priority interrupt controller
// assumes one clock domain; bound to pic_ctrl below

`timescale 1ns/1ns

module pic_ctrl_assertions (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// bus and handshake inputs
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_interrupt_ack_n,
	input wire logic [pic_pkg::PIC_NUM_IRQ-1:0] i_request_input,
	// design outputs
	input wire logic o_data_oe_n,
	input wire logic o_int,
	input wire logic [2:0] o_cas,
	input wire logic o_cas_oe_n,
	input wire logic o_role_pin_or_buffer_enable,
	input wire logic o_role_pin_or_buffer_enable_oe_n
);
	import pic_pkg::*;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	// cycles since any request line was high, saturating
	logic [3:0] req_idle_ff;
	logic [3:0] nxt_req_idle;

	always_comb begin
		nxt_req_idle = req_idle_ff;
		if (|i_request_input) begin
			nxt_req_idle = 4'h0;
		end else if (req_idle_ff != 4'hf) begin
			nxt_req_idle = req_idle_ff + 4'h1;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			req_idle_ff <= 4'hf;
		end else begin
			req_idle_ff <= nxt_req_idle;
		end
	end

	sequence s_read_held;
		(!i_cs_n && !i_rd_n && i_interrupt_ack_n) [*3];
	endsequence

	sequence s_bus_quiet;
		(i_rd_n && i_interrupt_ack_n) [*6];
	endsequence

	a_reset_quiet: assert property ($fell(i_rst) |->
		!o_int && o_data_oe_n && o_cas_oe_n) else $error("outputs busy at reset");
	a_read_drives: assert property (s_read_held |=> !o_data_oe_n)
		else $error("read not answered");
	a_bus_release: assert property (s_bus_quiet |-> o_data_oe_n)
		else $error("data bus not released");
	a_drive_cause: assert property ($fell(o_data_oe_n) |->
		(!$past(i_rd_n, 3) || !$past(i_interrupt_ack_n, 3)))
		else $error("data driven without request");
	a_int_cause: assert property (o_int |-> req_idle_ff < 4'h8)
		else $error("interrupt without request");
	a_cas_on_ack: assert property ($fell(o_cas_oe_n) |->
		!$past(i_interrupt_ack_n, 3)) else $error("cascade driven unasked");
	a_cas_steady: assert property (!o_cas_oe_n && !$past(o_cas_oe_n)
		|-> $stable(o_cas)) else $error("cascade code moved");
	a_buffer_follow: assert property (!o_role_pin_or_buffer_enable_oe_n
		|-> o_role_pin_or_buffer_enable == o_data_oe_n)
		else $error("buffer enable off data drive");

endmodule : pic_ctrl_assertions

bind pic_ctrl pic_ctrl_assertions u_pic_ctrl_assertions (.i_ref_clk,
	.i_rst, .i_cs_n, .i_rd_n, .i_interrupt_ack_n, .i_request_input,
	.o_data_oe_n, .o_int, .o_cas, .o_cas_oe_n, .o_role_pin_or_buffer_enable,
	.o_role_pin_or_buffer_enable_oe_n);

//--- pic_host.sv
// host processor model: bus writes, reads and acknowledge pulses
// assumes strobes of at least 3 clocks low and high, 100 MHz clock

`timescale 1ns/1ns

module pic_host (
	// clock
	input wire logic i_ref_clk,
	// device data bus
	input wire logic [7:0] i_data,
	input wire logic i_data_oe_n,
	// bus strobes
	output logic o_cs_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_a0,
	output logic o_ack_n,
	output logic [7:0] o_data
);
	initial begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_a0 = 1'b0;
		o_ack_n = 1'b1;
		o_data = 8'h00;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask : cyc

	// released data shows the inverse, never a stale copy
	task automatic wr(input logic a0, input logic [7:0] d);
		o_cs_n = 1'b0;
		o_a0 = a0;
		o_data = d;
		o_wr_n = 1'b0;
		cyc(4);
		o_wr_n = 1'b1;
		cyc(3);
		o_cs_n = 1'b1;
		o_data = ~d;
		cyc(4);
	endtask : wr

	// undriven bus returns unknown so it can never match
	task automatic rd(input logic a0, output logic [8:0] q);
		o_cs_n = 1'b0;
		o_a0 = a0;
		o_rd_n = 1'b0;
		cyc(5);
		q = {i_data_oe_n, i_data_oe_n ? 8'hxx : i_data};
		o_rd_n = 1'b1;
		o_cs_n = 1'b1;
		cyc(5);
	endtask : rd

	task automatic ack(output logic [8:0] q);
		o_ack_n = 1'b0;
		cyc(5);
		q = {i_data_oe_n, i_data};
		o_ack_n = 1'b1;
		cyc(5);
	endtask : ack

	// later words on high address, only those the first word asks for
	task automatic init(input logic [7:0] w1, input logic [7:0] w2,
		input logic [7:0] w3, input logic [7:0] w4);
		wr(1'b0, w1);
		wr(1'b1, w2);
		if (!w1[1]) begin
			wr(1'b1, w3);
		end
		if (w1[0]) begin
			wr(1'b1, w4);
		end
	endtask : init

	// one end command per device that served the request
	task automatic eoi(input logic [7:0] w);
		wr(1'b0, w);
	endtask : eoi

endmodule : pic_host

//--- priority_interrupt_ctrl_programming_test.sv
// self-checking bench: programs, interrupts and services the controller
// assumes one host; cascade code and role strap driven per scenario

`timescale 1ns/1ns

module priority_interrupt_ctrl_programming_test;
	import pic_pkg::*;

	logic i_ref_clk, i_rst, cs_n, rd_n, wr_n, a0, ack_n, oe_n, int_o;
	logic [7:0] req, wdata, rdata;
	logic [8:0] q;
	logic role_in, role_o, role_oe_n, cas_oe_n;
	logic [2:0] cas_in, cas_o;
	int fails = 0;
	int check_count = 0;

	pic_ctrl u_pic_ctrl (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_a0(a0),
		.i_data(wdata), .o_data(rdata), .o_data_oe_n(oe_n),
		.i_interrupt_ack_n(ack_n), .o_int(int_o), .i_request_input(req),
		.i_cas(cas_in), .o_cas(cas_o), .o_cas_oe_n(cas_oe_n),
		.i_role_pin_or_buffer_enable(role_in),
		.o_role_pin_or_buffer_enable(role_o),
		.o_role_pin_or_buffer_enable_oe_n(role_oe_n));

	pic_host u_pic_host (.i_ref_clk(i_ref_clk), .i_data(rdata),
		.i_data_oe_n(oe_n), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.o_a0(a0), .o_ack_n(ack_n), .o_data(wdata));

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		if (fails == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	// three-pulse call: opcode, low address, base byte 8'h5c
	task automatic serve8(input logic [7:0] low);
		u_pic_host.ack(q);
		check(q, {1'b0, PIC_CALL_OPCODE});
		u_pic_host.ack(q);
		check(q, {1'b0, low});
		u_pic_host.ack(q);
		check(q, 9'h05c);
	endtask : serve8

	// two-pulse vector: first pulse leaves the bus alone
	task automatic serve16(input logic [7:0] vec);
		u_pic_host.ack(q);
		check({q[8], 8'h00}, 9'h100);
		u_pic_host.ack(q);
		check(q, {1'b0, vec});
	endtask : serve16

	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// whole run is about 700 clocks
	initial begin
		repeat (40000) @(posedge i_ref_clk);
		fails++;
		complete_run();
	end

	initial begin
		i_rst = 1'b1;
		req = 8'h00;
		role_in = 1'b1;
		cas_in = 3'h0;
		repeat (5) @(posedge i_ref_clk);
		#1 i_rst = 1'b0;
		u_pic_host.cyc(2);
		// single, edge, spacing 4, no fourth word
		u_pic_host.init(8'hb6, 8'h5c, 8'h00, 8'h00);
		u_pic_host.rd(1'b1, q);
		check(q, 9'h000);
		u_pic_host.wr(1'b1, 8'ha5);
		u_pic_host.rd(1'b1, q);
		check(q, 9'h0a5);
		u_pic_host.wr(1'b1, 8'h01);
		req = 8'h09;
		u_pic_host.cyc(8);
		check({8'h00, int_o}, 9'h001);
		serve8(8'hac);
		u_pic_host.wr(1'b0, 8'h0b);
		u_pic_host.rd(1'b0, q);
		check(q, 9'h008);
		check({8'h00, int_o}, 9'h000);
		req = 8'h0b;
		u_pic_host.cyc(8);
		check({8'h00, int_o}, 9'h001);
		serve8(8'ha4);
		u_pic_host.eoi(8'h20);
		u_pic_host.rd(1'b0, q);
		check(q, 9'h008);
		u_pic_host.eoi(8'h63);
		u_pic_host.rd(1'b0, q);
		check(q, 9'h000);
		u_pic_host.wr(1'b1, 8'h00);
		u_pic_host.cyc(6);
		check({8'h00, int_o}, 9'h001);
		serve8(8'ha0);
		// level, fourth word: automatic end, 16-bit vectors
		u_pic_host.init(8'h1b, 8'h48, 8'h00, 8'h03);
		u_pic_host.rd(1'b1, q);
		check(q, 9'h000);
		u_pic_host.rd(1'b0, q);
		check(q, 9'h00b);
		u_pic_host.wr(1'b0, 8'h0b);
		u_pic_host.rd(1'b0, q);
		check(q, 9'h000);
		u_pic_host.wr(1'b0, 8'h80);
		check({8'h00, int_o}, 9'h001);
		serve16(8'h48);
		u_pic_host.rd(1'b0, q);
		check(q, 9'h000);
		serve16(8'h49);
		// back to edge sense with lines still high: no new edge
		u_pic_host.init(8'h16, 8'h5c, 8'h00, 8'h00);
		u_pic_host.cyc(8);
		check({8'h00, int_o}, 9'h000);
		// fresh edge on line 2: forced three-pulse calls, no auto end
		req = 8'h0f;
		u_pic_host.cyc(8);
		serve8(8'h08);
		u_pic_host.wr(1'b0, 8'h0b);
		u_pic_host.rd(1'b0, q);
		check(q, 9'h004);
		// lower line 3 stays blocked until special masking
		req = 8'h04;
		u_pic_host.cyc(4);
		req = 8'h0c;
		u_pic_host.cyc(8);
		check({8'h00, int_o}, 9'h000);
		u_pic_host.wr(1'b0, 8'h68);
		check({8'h00, int_o}, 9'h001);
		u_pic_host.wr(1'b0, 8'h48);
		check({8'h00, int_o}, 9'h000);
		u_pic_host.wr(1'b0, 8'h28);
		check({8'h00, int_o}, 9'h000);
		// buffered master: a low role pin must not matter
		req = 8'h00;
		role_in = 1'b0;
		u_pic_host.init(8'h15, 8'h5c, 8'h04, 8'h0c);
		check({7'h00, role_oe_n, role_o}, 9'h001);
		req = 8'h04;
		u_pic_host.cyc(8);
		u_pic_host.ack(q);
		check(q, {1'b0, PIC_CALL_OPCODE});
		check({5'h00, cas_oe_n, cas_o}, 9'h002);
		u_pic_host.ack(q);
		check({q[8], 8'h00}, 9'h100);
		u_pic_host.ack(q);
		check({q[8], 8'h00}, 9'h100);
		check({8'h00, cas_oe_n}, 9'h001);
		// unbuffered slave with identity 2
		req = 8'h00;
		u_pic_host.init(8'h14, 8'h5c, 8'h02, 8'h00);
		check({8'h00, role_oe_n}, 9'h001);
		req = 8'h10;
		cas_in = 3'h2;
		u_pic_host.cyc(8);
		u_pic_host.ack(q);
		check({q[8], 8'h00}, 9'h100);
		u_pic_host.ack(q);
		check(q, 9'h010);
		cas_in = 3'h5;
		u_pic_host.ack(q);
		check({q[8], 8'h00}, 9'h100);
		complete_run();
	end

endmodule : priority_interrupt_ctrl_programming_test
